// ==== rtl/core_ctl_defs.svh ====
// constants for the core reset, halt and interrupt control block
// assumes inclusion by bare name from the module and the bench
`ifndef CORE_CTL_DEFS_SVH
`define CORE_CTL_DEFS_SVH

// register byte offsets on the AXI4-Lite slave
`define OFS_IRQ_MASK      12'h000
`define OFS_STATUS_CTL    12'h004
`define OFS_PENDING       12'h008
`define OFS_CORE_STATE    12'h00C
`define OFS_VEC_INSN      12'h010
`define OFS_VEC_RESULT    12'h014
`define OFS_CAUSE         12'h018

// field positions in the status control register
`define BIT_GIE           0
`define BIT_SAVED_GIE     1

// reset values
`define RST_MASK          32'h0000_0000
`define RST_STATUS        2'h0

// custom instruction encoding
`define VEC_OPCODE        6'h32
`define VEC_FUNC          3'h1
`define VEC_NEG           32'hFFFF_FFFF

// timing: fetch and acknowledge repeat period while held in reset
`define RESET_POLL_NS     160
`define CLK_PERIOD_NS     10

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ==== rtl/core_ctl_pkg.sv ====
// types shared by the core reset, halt and interrupt control block
// assumes core_ctl_defs.svh sits on the include path
package core_ctl_pkg;
	// run state of the core; gray coded along run, drain, held, halted
	typedef enum logic [1:0] {
		ST_RUN    = 2'h0,
		ST_DRAIN  = 2'h1,
		ST_HELD   = 2'h3,
		ST_HALTED = 2'h2
	} core_state_t;
endpackage : core_ctl_pkg

// ==== rtl/core_reset_halt_irq_control.sv ====
// reset, halt, exception and interrupt control at the edge of a core
// assumes pipeline handshakes on aclk and an AXI4-Lite master
//
// How it works
// - global reset forces reset state immediately
// - local reset drains pipeline, then resets
// - acknowledge pulses once, then periodically while held
// - core stays reset while request stays high
// - held core periodically reads reset address, discards
// - local reset ignored while debug paused
// - local reset honoured when debug releases control
// - halt request pauses, jumps to break, acknowledges
// - halt request while paused changes nothing
// - every exception goes to one address, except one met by a halt request in the same cycle, which goes to break
// - exception address is a fixed parameter
// - exceptions redirect on the next cycle, without waiting on pipe_empty for older instructions
// - thirty-two level interrupt request inputs
// - no hardware priority, nesting left to software
// - per-source interrupt mask register
// - global interrupt enable bit in status
// - interrupt taken only when enable, request, mask
// - vector lookup: negative or eight times index
// - vector lookup is a priority encoder
// - vector lookup decoded as R-type custom instruction
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "core_ctl_defs.svh"

module core_reset_halt_irq_control #(
	parameter int          NUM_IRQ    = 32,
	parameter logic [31:0] RESET_ADDR = 32'h0000_0000,
	parameter logic [31:0] EXC_ADDR   = 32'h0000_0020,
	parameter logic [31:0] BREAK_ADDR = 32'h0000_0040
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// requests from system reset and debug logic (async pins)
	input  wire logic        local_reset_req,
	input  wire logic        halt_req,
	input  wire logic        debug_release,
	input  wire logic [31:0] irq_in,
	// pipeline handshakes (same clock)
	input  wire logic        pipe_empty,
	input  wire logic        sw_exception,
	// outputs to the core and system
	output logic             core_reset,
	output logic             local_reset_ack,
	output logic             halt_ack,
	output logic             fetch_req,
	output logic [31:0]      fetch_addr,
	output logic             pipe_stall,
	output logic             redirect,
	output logic [31:0]      redirect_addr,
	output logic             irq_taken,
	// AXI4-Lite slave
	input  wire logic [11:0] s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [11:0] s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	localparam int POLL_CYC = `RESET_POLL_NS / `CLK_PERIOD_NS;

	if (NUM_IRQ < 1 || NUM_IRQ > 32 ||
		POLL_CYC < 1 || POLL_CYC > 256) begin : g_bad_cfg
		$error("NUM_IRQ or poll period out of range");
	end

	// priority encoder over pending bits, lowest index wins
	function automatic logic [31:0] vec_of(input logic [31:0] p);
		logic [31:0] r;
		r = `VEC_NEG;
		for (int i = 31; i >= 0; i--) begin
			if (p[i])
				r = 32'(i) << 3;
		end
		return r;
	endfunction : vec_of

	// merge written bytes into a register word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		end
		return r;
	endfunction : merge

	// two-flop synchronisers for pin inputs
	logic        lrr_s1_q, lrr_q, hr_s1_q, hr_q, dr_s1_q, dr_q;
	logic [31:0] irq_s1_q, irq_q;
	always_ff @(posedge aclk) begin
		lrr_s1_q <= local_reset_req;
		lrr_q    <= lrr_s1_q;
		hr_s1_q  <= halt_req;
		hr_q     <= hr_s1_q;
		dr_s1_q  <= debug_release;
		dr_q     <= dr_s1_q;
		irq_s1_q <= irq_in;
		irq_q    <= irq_s1_q;
	end

	core_ctl_pkg::core_state_t state_q;
	logic [31:0] mask_q;
	logic [1:0]  status_q;
	logic [31:0] pending_q;
	logic [31:0] vec_insn_q;
	logic [31:0] vec_res_q;
	logic        cause_hw_q;
	logic [7:0]  poll_q;
	logic        polling;
	logic        irq_fire;
	logic        exc_fire;
	logic        halting;
	logic [NUM_IRQ-1:0] conn;

	assign conn     = irq_q[NUM_IRQ-1:0];
	assign polling  = state_q == core_ctl_pkg::ST_HELD;
	assign halting  = state_q == core_ctl_pkg::ST_HALTED;
	// global enable gate over any pending source; no priority among sources here
	assign irq_fire = status_q[`BIT_GIE] && |pending_q;
	assign exc_fire = (irq_fire || sw_exception) && !halting &&
		state_q == core_ctl_pkg::ST_RUN;

	// pending register tracks request and mask every cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pending_q <= 32'h0000_0000;
		else
			pending_q <= 32'(conn) & mask_q;
	end

	// core state: global reset is immediate, local reset drains first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= core_ctl_pkg::ST_HELD;
		end else begin
			case (state_q)
			core_ctl_pkg::ST_RUN: begin
				if (hr_q)
					state_q <= core_ctl_pkg::ST_HALTED;
				else if (lrr_q)
					state_q <= core_ctl_pkg::ST_DRAIN;
			end
			core_ctl_pkg::ST_DRAIN: begin
				if (pipe_empty)
					state_q <= core_ctl_pkg::ST_HELD;
			end
			core_ctl_pkg::ST_HELD: begin
				if (!lrr_q)
					state_q <= core_ctl_pkg::ST_RUN;
			end
			core_ctl_pkg::ST_HALTED: begin
				// halt request here is ignored; local reset only on release
				if (dr_q)
					state_q <= lrr_q ? core_ctl_pkg::ST_DRAIN
						: core_ctl_pkg::ST_RUN;
			end
			default: state_q <= core_ctl_pkg::ST_HELD;
			endcase
		end
	end

	// poll period counter while held in reset
	always_ff @(posedge aclk) begin
		if (!aresetn || !polling || poll_q == 8'(POLL_CYC - 1))
			poll_q <= 8'h00;
		else
			poll_q <= poll_q + 8'h01;
	end

	// acknowledge on entry and each poll period; dummy fetch likewise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			local_reset_ack <= 1'b0;
			fetch_req       <= 1'b0;
			fetch_addr      <= 32'h0000_0000;
		end else begin
			local_reset_ack <= polling && lrr_q &&
				poll_q == 8'h00;
			fetch_req       <= polling && poll_q == 8'h00;
			fetch_addr      <= RESET_ADDR;
		end
	end

	// core-facing levels and redirect pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_reset    <= 1'b1;
			halt_ack      <= 1'b0;
			pipe_stall    <= 1'b1;
			redirect      <= 1'b0;
			redirect_addr <= 32'h0000_0000;
			irq_taken     <= 1'b0;
		end else begin
			core_reset <= state_q == core_ctl_pkg::ST_HELD;
			halt_ack   <= state_q == core_ctl_pkg::ST_HALTED;
			// stall stops new issue so older work retires first
			pipe_stall <= state_q != core_ctl_pkg::ST_RUN ||
				exc_fire;
			redirect   <= exc_fire ||
				(state_q == core_ctl_pkg::ST_RUN && hr_q);
			if (state_q == core_ctl_pkg::ST_RUN && hr_q)
				redirect_addr <= BREAK_ADDR;
			else if (exc_fire)
				redirect_addr <= EXC_ADDR;
			irq_taken  <= irq_fire && exc_fire;
		end
	end

	// cause and saved enable captured at exception entry
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cause_hw_q <= 1'b0;
		else if (exc_fire)
			cause_hw_q <= irq_fire;
	end

	function automatic logic insn_ok_q(input logic [31:0] w);
		return w[5:0] == `VEC_OPCODE && w[16:14] == `VEC_FUNC &&
			w[31:22] == 10'h000;
	endfunction : insn_ok_q

	// vector lookup runs on a write of a valid word; taken data, not bus
	logic        insn_ok;
	logic [31:0] insn_w;
	assign insn_w  = merge(vec_insn_q, wd_q, ws_q);
	assign insn_ok = insn_ok_q(insn_w);

	// AXI write path: take address and data in either order
	logic        aw_have_q, w_have_q;
	logic [11:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;
	logic        do_write;
	assign do_write = aw_have_q && w_have_q && !s_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_q      <= 12'h000;
			wd_q      <= 32'h0000_0000;
			ws_q      <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= s_awaddr;
			end else if (do_write) begin
				aw_have_q <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_have_q <= 1'b1;
				wd_q     <= s_wdata;
				ws_q     <= s_wstrb;
			end else if (do_write) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= `RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready)
				s_awready <= 1'b0;
			else if (s_bvalid && s_bready)
				s_awready <= 1'b1;
			if (s_wvalid && s_wready)
				s_wready <= 1'b0;
			else if (s_bvalid && s_bready)
				s_wready <= 1'b1;
			if (do_write) begin
				s_bvalid <= 1'b1;
				if (aw_q == `OFS_IRQ_MASK || aw_q == `OFS_STATUS_CTL ||
					aw_q == `OFS_VEC_INSN)
					s_bresp <= `RESP_OKAY;
				else
					s_bresp <= `RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// writable registers; saved enable snaps on exception entry
	logic [31:0] sts_w;
	assign sts_w = merge({30'h0, status_q}, wd_q, ws_q);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q     <= `RST_MASK;
			status_q   <= `RST_STATUS;
			vec_insn_q <= 32'h0000_0000;
			vec_res_q  <= `VEC_NEG;
		end else begin
			if (do_write && aw_q == `OFS_IRQ_MASK)
				mask_q <= merge(mask_q, wd_q, ws_q);
			if (exc_fire) begin
				// entry clears the live enable so nesting is a software act
				status_q[`BIT_SAVED_GIE] <= status_q[`BIT_GIE];
				status_q[`BIT_GIE]       <= 1'b0;
			end else if (do_write && aw_q == `OFS_STATUS_CTL) begin
				status_q <= sts_w[1:0];
			end
			if (do_write && aw_q == `OFS_VEC_INSN) begin
				vec_insn_q <= insn_w;
				if (insn_ok)
					vec_res_q <= (pending_q == 32'h0000_0000 ||
						!status_q[`BIT_SAVED_GIE]) ? `VEC_NEG
						: vec_of(pending_q);
			end
		end
	end

	// AXI read path, one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= `RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rresp   <= `RESP_OKAY;
			if (s_araddr == `OFS_IRQ_MASK)
				s_rdata <= mask_q;
			else if (s_araddr == `OFS_STATUS_CTL)
				s_rdata <= {30'h0, status_q};
			else if (s_araddr == `OFS_PENDING)
				s_rdata <= pending_q;
			else if (s_araddr == `OFS_CORE_STATE)
				s_rdata <= {30'h0, state_q};
			else if (s_araddr == `OFS_VEC_INSN)
				s_rdata <= vec_insn_q;
			else if (s_araddr == `OFS_VEC_RESULT)
				s_rdata <= vec_res_q;
			else if (s_araddr == `OFS_CAUSE)
				s_rdata <= {31'h0, cause_hw_q};
			else begin
				s_rdata <= 32'h0000_0000;
				s_rresp <= `RESP_SLVERR;
			end
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// assertions
	AST_HELD_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == core_ctl_pkg::ST_HELD |=> core_reset)
		else $error("core_reset low while held");
	AST_ACK_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
		local_reset_ack |=> !local_reset_ack)
		else $error("ack longer than one cycle");
	AST_ACK_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
		local_reset_ack |-> $past(polling))
		else $error("ack outside reset state");
	AST_HALT_IGN: assert property (@(posedge aclk) disable iff (!aresetn)
		halting && !dr_q |=> halting)
		else $error("halted core left without release");
	AST_HALT_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == core_ctl_pkg::ST_RUN && hr_q |=> ##1 halt_ack)
		else $error("halt not acknowledged");
	AST_EXC_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
		exc_fire && !hr_q |=> redirect && redirect_addr == EXC_ADDR)
		else $error("exception not sent to common address");
	AST_IRQ_COND: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_taken |-> $past(status_q[`BIT_GIE]) && $past(|pending_q))
		else $error("interrupt taken without all conditions");
	AST_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 pending_q == ($past(32'(conn)) & $past(mask_q)))
		else $error("pending does not follow request and mask");
	AST_DRAIN: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == core_ctl_pkg::ST_DRAIN && !pipe_empty |=>
		state_q == core_ctl_pkg::ST_DRAIN)
		else $error("reset entered before pipeline drained");
endmodule : core_reset_halt_irq_control

// ==== tb/far_side_model.sv ====
// far-side model: system reset requester and pipeline drain status
// assumes the bench pulses start_rst for one cycle per request
`timescale 1ns/1ps
module far_side_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start_rst,
	input  wire logic slow,
	input  wire logic hold_more,
	input  wire logic local_reset_ack,
	output logic      local_reset_req,
	output logic      pipe_empty
);
	logic [3:0] busy_q;

	// request held until the ack is seen; hold_more keeps it for more acks
	always_ff @(posedge aclk) begin
		if (!aresetn)
			local_reset_req <= 1'b0;
		else if (start_rst)
			local_reset_req <= 1'b1;
		else if (local_reset_ack && !hold_more)
			local_reset_req <= 1'b0;
	end

	// older work drains in one cycle, or in fifteen to stress the drain
	always_ff @(posedge aclk) begin
		if (!aresetn)
			busy_q <= 4'h0;
		else if (start_rst)
			busy_q <= slow ? 4'hF : 4'h1;
		else if (busy_q != 4'h0)
			busy_q <= busy_q - 4'h1;
	end
	assign pipe_empty = (busy_q == 4'h0);
endmodule : far_side_model

// ==== tb/tb_top.sv ====
// self-checking bench for the core reset, halt and interrupt control
// assumes far_side_model drives the local request and the drain status
`timescale 1ns/1ps
`include "core_ctl_defs.svh"
module tb_top;
	localparam logic [31:0] RST_A = 32'h0000_1000;
	localparam logic [31:0] EXC_A = 32'h0000_2020;
	localparam logic [31:0] BRK_A = 32'h0000_3040;
	localparam logic [31:0] V_OK  = {10'h000, 5'h05, 3'h1, 8'h00, 6'h32};
	localparam logic [31:0] V_BAD = {10'h000, 5'h05, 3'h1, 8'h00, 6'h31};
	logic        aclk, aresetn, halt_req, debug_release, sw_exception;
	logic [31:0] irq_in, s_wdata, s_rdata, fetch_addr, redirect_addr;
	logic [11:0] s_awaddr, s_araddr;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp, rsp;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
	logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
	logic        core_reset, local_reset_ack, halt_ack, fetch_req;
	logic        pipe_stall, redirect, irq_taken, local_reset_req;
	logic        pipe_empty, start_rst, slow, hold_more, ack_prev;
	logic [31:0] redir_a, fetch_a, rd_d;
	int          err_total, total_checks, cyc, irq_cnt, redir_cnt;
	int          fetch_cnt, ack_cnt, ack_t, ack_gap, halt_cnt, run_cnt, wide;

	core_reset_halt_irq_control #(.RESET_ADDR(RST_A), .EXC_ADDR(EXC_A),
		.BREAK_ADDR(BRK_A)) u_core_reset_halt_irq_control (
		.aclk, .aresetn, .local_reset_req, .halt_req, .debug_release,
		.irq_in, .pipe_empty, .sw_exception, .core_reset, .local_reset_ack,
		.halt_ack, .fetch_req, .fetch_addr, .pipe_stall, .redirect,
		.redirect_addr, .irq_taken, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready);
	far_side_model u_far_side_model (.aclk, .aresetn, .start_rst, .slow,
		.hold_more, .local_reset_ack, .local_reset_req, .pipe_empty);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// event counters sampled mid-cycle, away from the launching edge
	always @(negedge aclk) begin
		cyc++;
		if (irq_taken === 1'b1) irq_cnt++;
		if (redirect === 1'b1) begin
			redir_cnt++;
			redir_a = redirect_addr;
		end
		if (fetch_req === 1'b1) begin
			fetch_cnt++;
			fetch_a = fetch_addr;
		end
		if (local_reset_ack === 1'b1) begin
			ack_cnt++;
			ack_gap = cyc - ack_t;
			ack_t = cyc;
		end
		if (local_reset_ack === 1'b1 && ack_prev === 1'b1) wide++;
		ack_prev = local_reset_ack;
		if (halt_ack === 1'b1) halt_cnt++;
		if (core_reset === 1'b0) run_cnt++;
	end

	task automatic close_out;
		if (err_total == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// a wait that runs out is reported as a mismatch and ends the run
	task automatic await(ref int c, input int base, input int lim);
		int n;
		n = 0;
		while (c == base && n < lim) begin
			@(posedge aclk);
			n++;
		end
		if (c == base) begin
			chk(32'h0, 32'h1);
			close_out();
		end
	endtask : await

	// address and data offered together; bready held until bvalid
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rsp = 2'h3;
		@(posedge aclk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (rsp === 2'h3 && n < 40) begin
			@(posedge aclk);
			n++;
			if (s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wready === 1'b1) s_wvalid <= 1'b0;
			if (s_bvalid === 1'b1) begin
				rsp = s_bresp;
				s_bready <= 1'b0;
			end
		end
		if (rsp === 2'h3) await(n, n, 0);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		rsp = 2'h3;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		while (rsp === 2'h3 && n < 40) begin
			@(posedge aclk);
			n++;
			if (s_arready === 1'b1) s_arvalid <= 1'b0;
			if (s_rvalid === 1'b1) begin
				rsp = s_rresp;
				rd_d = s_rdata;
				s_rready <= 1'b0;
			end
		end
		if (rsp === 2'h3) await(n, n, 0);
	endtask : rd

	task automatic t_boot;
		await(run_cnt, 0, 20);
		rd(`OFS_IRQ_MASK);
		chk(rd_d, `RST_MASK);
		rd(`OFS_STATUS_CTL);
		chk(rd_d, 32'h0);
		rd(12'h0FC);
		chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
		wr(`OFS_PENDING, 32'hFFFF_FFFF);
		chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
	endtask : t_boot

	task automatic t_irq;
		wr(`OFS_IRQ_MASK, 32'hFFFF_FFFF);
		irq_in <= 32'h8000_0000;
		repeat (4) @(posedge aclk);
		rd(`OFS_PENDING);
		chk(rd_d, 32'h8000_0000);
		wr(`OFS_IRQ_MASK, 32'h0000_0050);
		irq_in <= 32'h0000_0070;
		repeat (4) @(posedge aclk);
		rd(`OFS_PENDING);
		chk(rd_d, 32'h0000_0050);
		chk(irq_cnt, 0);
		wr(`OFS_STATUS_CTL, 32'h1);
		await(irq_cnt, 0, 20);
		await(redir_cnt, 0, 20);
		chk(redir_a, EXC_A);
		rd(`OFS_STATUS_CTL);
		chk(rd_d, 32'h2);
		rd(`OFS_CAUSE);
		chk(rd_d, 32'h1);
		wr(`OFS_VEC_INSN, V_OK);
		rd(`OFS_VEC_RESULT);
		chk(rd_d, 32'h0000_0020);
		irq_in <= 32'h0;
		repeat (4) @(posedge aclk);
		wr(`OFS_VEC_INSN, V_BAD);
		rd(`OFS_VEC_RESULT);
		chk(rd_d, 32'h0000_0020);
		wr(`OFS_VEC_INSN, V_OK);
		rd(`OFS_VEC_RESULT);
		chk(rd_d, `VEC_NEG);
		irq_in <= 32'h0000_0050;
		wr(`OFS_STATUS_CTL, 32'h0);
		wr(`OFS_VEC_INSN, V_OK);
		rd(`OFS_VEC_RESULT);
		chk(rd_d, `VEC_NEG);
		irq_in <= 32'h0;
		// a trap with the global enable set still yields a negative lookup
		wr(`OFS_STATUS_CTL, 32'h1);
		sw_exception <= 1'b1;
		@(posedge aclk);
		sw_exception <= 1'b0;
		await(redir_cnt, 1, 20);
		chk(redir_a, EXC_A);
		rd(`OFS_CAUSE);
		chk(rd_d, 32'h0);
		wr(`OFS_VEC_INSN, V_OK);
		rd(`OFS_VEC_RESULT);
		chk(rd_d, `VEC_NEG);
	endtask : t_irq

	task automatic t_lreset;
		int b;
		int f;
		int r;
		b = ack_cnt;
		f = fetch_cnt;
		slow <= 1'b1;
		hold_more <= 1'b1;
		start_rst <= 1'b1;
		@(posedge aclk);
		start_rst <= 1'b0;
		repeat (10) @(posedge aclk);
		chk({31'h0, core_reset}, 32'h0);
		await(ack_cnt, b, 40);
		chk({31'h0, core_reset}, 32'h1);
		r = run_cnt;
		await(ack_cnt, b + 1, 40);
		chk(ack_gap, `RESET_POLL_NS / `CLK_PERIOD_NS);
		chk(fetch_a, RST_A);
		chk({31'h0, fetch_cnt > f + 1}, 32'h1);
		hold_more <= 1'b0;
		await(ack_cnt, b + 2, 40);
		chk(run_cnt, r);
		await(run_cnt, r, 20);
		chk(wide, 0);
	endtask : t_lreset

	task automatic t_halt;
		int b;
		int a;
		int r;
		b = redir_cnt;
		halt_req <= 1'b1;
		await(redir_cnt, b, 20);
		chk(redir_a, BRK_A);
		await(halt_cnt, 0, 20);
		halt_req <= 1'b0;
		repeat (4) @(posedge aclk);
		halt_req <= 1'b1;
		a = ack_cnt;
		slow <= 1'b0;
		hold_more <= 1'b1;
		start_rst <= 1'b1;
		@(posedge aclk);
		start_rst <= 1'b0;
		repeat (20) @(posedge aclk);
		chk(redir_cnt, b + 1);
		chk({31'h0, halt_ack}, 32'h1);
		chk(ack_cnt, a);
		chk({31'h0, core_reset}, 32'h0);
		rd(`OFS_CORE_STATE);
		chk(rd_d, {30'h0, core_ctl_pkg::ST_HALTED});
		halt_req <= 1'b0;
		debug_release <= 1'b1;
		await(ack_cnt, a, 40);
		chk({31'h0, core_reset}, 32'h1);
		debug_release <= 1'b0;
		hold_more <= 1'b0;
		r = run_cnt;
		await(ack_cnt, a + 1, 40);
		await(run_cnt, r, 20);
	endtask : t_halt

	// global reset lands while a local reset is still draining
	task automatic t_grst;
		int r;
		slow <= 1'b1;
		start_rst <= 1'b1;
		@(posedge aclk);
		start_rst <= 1'b0;
		// request needs three edges to reach drain; pipeline still busy
		repeat (5) @(posedge aclk);
		chk({30'h0, core_reset, pipe_stall}, 32'h1);
		aresetn <= 1'b0;
		// synchronous reset acts at the next edge, drain or not
		@(posedge aclk);
		@(negedge aclk);
		chk({30'h0, core_reset, pipe_stall}, 32'h3);
		@(posedge aclk);
		aresetn <= 1'b1;
		r = run_cnt;
		await(run_cnt, r, 20);
	endtask : t_grst

	initial begin
		{aresetn, halt_req, debug_release, sw_exception} = 4'h0;
		{start_rst, slow, hold_more} = 3'h0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{irq_in, s_wdata, s_awaddr, s_araddr} = 88'h0;
		s_wstrb = 4'hF;
		repeat (2) @(posedge aclk);
		chk({31'h0, core_reset}, 32'h1);
		aresetn <= 1'b1;
		t_boot();
		t_irq();
		t_lreset();
		t_halt();
		t_grst();
		close_out();
	end
endmodule : tb_top
